// *** src/wdt_cfg.svh ***
// constants of the windowed watchdog: register offset, option byte fields,
// reset values and count geometry
// assumes inclusion by bare name from the package and modules
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

`define WDT_RESTART_ADDR 16'hFF99
`define WDT_RESTART_KEY 8'hAC
`define WDT_RESTART_RST_ON 8'h9A
`define WDT_RESTART_RST_OFF 8'h1A

`define WDT_OPT_LOCK_BIT 0
`define WDT_OPT_OVF_LSB 1
`define WDT_OPT_OVF_MSB 3
`define WDT_OPT_EN_BIT 4
`define WDT_OPT_WIN_LSB 5
`define WDT_OPT_WIN_MSB 6
`define WDT_OPT_RST 8'h00

`define WDT_CNT_W 17
`define WDT_OVF_BASE_EXP 5'h0A
`define WDT_CNT_RST 17'h0_0000
`define WDT_EXEMPT_LO 16'hFB00
`define WDT_ADDR_W 16

`endif

// *** src/wdt_pkg.sv ***
// types of the windowed watchdog: phase enumeration and state records
// assumes the constants header is on the include path
`include "wdt_cfg.svh"

package wdt_pkg;

    typedef enum logic [1:0] {
        PH_OFF,
        PH_RUN,
        PH_TRIP
    } wdt_phase_e;

    typedef struct packed {
        wdt_phase_e phase;
        logic [`WDT_CNT_W-1:0] count;
        logic [7:0] opt;
        logic optLoaded;
        logic firstDone;
        logic errPend;
        logic resetReq;
        logic causeSet;
        logic [7:0] rdata;
    } wdt_state_s;

    typedef struct packed {
        logic prevLevel;
        logic tick;
    } wdt_tick_state_s;

endpackage

// *** src/wdt_tick_gen.sv ***
// low-speed tick extractor: one pulse per rising edge of the low-speed
// oscillation clock, only while the core allows its source to run
// assumes lsClkIn is already synchronous to clock
`timescale 1ns/1ps

module wdt_tick_gen (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic lsClkIn,
    wdt_tick_if.src tickPort
);

    wdt_pkg::wdt_tick_state_s state_reg;
    wdt_pkg::wdt_tick_state_s state_next;

    always_comb begin
        state_next = state_reg;
        state_next.prevLevel = lsClkIn;
        // the edge is still tracked while gated, so no stale edge fires later
        state_next.tick = lsClkIn & ~state_reg.prevLevel & tickPort.run; // R1
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tickPort.tick = state_reg.tick;

endmodule

// *** src/wdt_tick_if.sv ***
// carrier between the watchdog core and its low-speed tick extractor
// assumes both ends run on the system clock
`timescale 1ns/1ps

interface wdt_tick_if;
    logic run;
    logic tick;

    modport src (
        input run,
        output tick
    );

    modport snk (
        output run,
        input tick
    );
endinterface

// *** src/wdt_top.sv ***
// windowed watchdog core: restart register, overflow counter on the
// low-speed clock, window check and illegal fetch/access detection
// assumes the CPU port, option byte and memory limits are synchronous to
// clock; the chip answers resetReq with an internalRst pulse
`timescale 1ns/1ps
`include "wdt_cfg.svh"

// Overview of operation
// R1: count only on low-speed oscillator ticks
// R2: key write clears counter, restarts from zero
// R3: reset value 9A or 1A per enable
// R4: reads always return the reset value
// R5: non-key write value raises internal reset
// R6: single-bit operation on register raises reset
// R7: illegal write waits for stopped clock resume
// R8: enable option starts counting and detection
// R9: overflow code selects 2^(10+code) periods
// R10: window field separates open, closed writes
// R11: open part is last 25-100 percent
// R12: first restart after reset skips window check
// R13: closed-window restart write raises reset
// R14: overflow without restart raises internal reset
// R15: fetch outside configured memory raises reset
// R16: access outside areas resets, FB00-FFFF exempt
// R17: restart applies within two low-speed periods
// R18: restart one step before overflow still clears
// R19: lock option 0 stops in HALT/STOP
// R20: count resumes from held value after standby
// R21: oscillator stop bit holds count when unlocked
// R22: counting continues during flash self-programming
// R23: overflow code 0 with window 00 forbidden
// R24: watchdog reset sets reset-cause flag
// R25: internal reset clears counter, fresh count
module wdt_top #(
    parameter int CNT_W = `WDT_CNT_W,
    parameter int ADDR_W = `WDT_ADDR_W
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic internalRst,
    input wire logic lsClkIn,
    input wire logic [7:0] optionByte,
    input wire logic haltMode,
    input wire logic stopMode,
    input wire logic lowspeed_osc_stop_bit,
    input wire logic flashSelfProg,
    input wire logic busWrite,
    input wire logic busRead,
    input wire logic busBitOp,
    input wire logic [ADDR_W-1:0] busAddr,
    input wire logic [7:0] busWdata,
    input wire logic fetchValid,
    input wire logic [ADDR_W-1:0] fetchAddr,
    input wire logic dataAccValid,
    input wire logic [ADDR_W-1:0] dataAccAddr,
    input wire logic [ADDR_W-1:0] codeAreaEnd,
    input wire logic [ADDR_W-1:0] ramAreaStart,
    input wire logic [ADDR_W-1:0] ramAreaEnd,
    output logic [7:0] busRdata,
    output logic resetReq,
    output logic wdog_reset_cause_flag,
    output logic [CNT_W-1:0] countValue
);

    wdt_pkg::wdt_state_s state_reg;
    wdt_pkg::wdt_state_s state_next;

    wdt_tick_if tickBus ();

    wdt_tick_gen tickGen (
        .clock(clock),
        .sys_rst(sys_rst),
        .lsClkIn(lsClkIn),
        .tickPort(tickBus.src)
    );

    // last count value before overflow for a 3-bit overflow code
    function automatic logic [CNT_W-1:0] ovfLast(input logic [2:0] code);
        logic [CNT_W:0] period;
        period = '0;
        period = (CNT_W+1)'(1) << (`WDT_OVF_BASE_EXP + 5'(code)); // R9
        return CNT_W'(period - (CNT_W+1)'(1));
    endfunction

    // first count value of the open window; the open part sits at the end
    function automatic logic [CNT_W-1:0] openStart(
        input logic [2:0] code,
        input logic [1:0] win
    );
        logic [CNT_W:0] quarter;
        logic [CNT_W+1:0] prod;
        quarter = '0;
        prod = '0;
        quarter = ((CNT_W+1)'(1) << (`WDT_OVF_BASE_EXP + 5'(code))) >> 2;
        prod = (CNT_W+2)'(quarter) * (CNT_W+2)'(2'd3 - win); // R11
        return CNT_W'(prod);
    endfunction

    // restart register value seen on reads and after reset
    function automatic logic [7:0] restartValue(input logic enOpt);
        return enOpt ? `WDT_RESTART_RST_ON : `WDT_RESTART_RST_OFF; // R3
    endfunction

    // address lies inside the code area or the RAM area
    function automatic logic inMapped(input logic [ADDR_W-1:0] addr);
        return (addr <= codeAreaEnd) ||
               ((addr >= ramAreaStart) && (addr <= ramAreaEnd));
    endfunction

    logic [7:0] optNow;
    logic enOpt;
    logic lockOpt;
    logic [2:0] ovfCode;
    logic [1:0] winCode;
    logic srcRun;
    logic tick;
    logic regWrite;
    logic badValue;
    logic keyWrite;
    logic closedHit;
    logic fetchBad;
    logic accessBad;
    logic atLast;
    logic tripNow;

    always_comb begin
        optNow = state_reg.optLoaded ? state_reg.opt : optionByte;
        enOpt = optNow[`WDT_OPT_EN_BIT];
        lockOpt = optNow[`WDT_OPT_LOCK_BIT];
        ovfCode = optNow[`WDT_OPT_OVF_MSB:`WDT_OPT_OVF_LSB];
        winCode = optNow[`WDT_OPT_WIN_MSB:`WDT_OPT_WIN_LSB];
    end

    // the source clock is gated by standby and by the oscillator stop bit
    // only when the lock option allows it; flash self-programming has no
    // effect on it at all
    always_comb begin
        srcRun = lockOpt |
                 ~(haltMode | stopMode | lowspeed_osc_stop_bit); // R19 R21 R22
    end

    assign tickBus.run = srcRun && (state_reg.phase == wdt_pkg::PH_RUN);
    assign tick = tickBus.tick;

    always_comb begin
        regWrite = busWrite && (busAddr == ADDR_W'(`WDT_RESTART_ADDR));
        badValue = regWrite && (busWdata != `WDT_RESTART_KEY); // R5
        keyWrite = regWrite && !busBitOp && !badValue;
        closedHit = keyWrite && state_reg.firstDone && // R12
                    (state_reg.count < openStart(ovfCode, winCode)); // R10 R13
        fetchBad = fetchValid && !inMapped(fetchAddr); // R15
        accessBad = dataAccValid && !inMapped(dataAccAddr) &&
                    (dataAccAddr < ADDR_W'(`WDT_EXEMPT_LO)); // R16
        atLast = (state_reg.count == ovfLast(ovfCode));
    end

    always_comb begin
        state_next = state_reg;
        state_next.resetReq = 1'b0;
        state_next.causeSet = 1'b0;
        tripNow = 1'b0;
        // the option byte is caught on the first cycle after reset release
        if (!state_reg.optLoaded) begin
            state_next.opt = optionByte;
            state_next.optLoaded = 1'b1;
        end
        state_next.rdata = restartValue(enOpt); // R4
        case (state_reg.phase)
            wdt_pkg::PH_OFF: begin
                if (!state_reg.optLoaded && enOpt) begin
                    state_next.phase = wdt_pkg::PH_RUN; // R8
                end
            end
            wdt_pkg::PH_RUN: begin
                // an illegal write is parked while the source clock is
                // stopped and acted on once it runs again
                if ((regWrite && busBitOp) || badValue || closedHit) begin
                    state_next.errPend = 1'b1; // R6 R7
                end
                if (fetchBad || accessBad) begin
                    tripNow = 1'b1;
                end
                if ((state_next.errPend || state_reg.errPend) && srcRun) begin
                    tripNow = 1'b1; // R7
                end
                if (keyWrite && !closedHit) begin
                    // applied at once, so the overflow moves by under one
                    // low-speed period, inside the allowed slack
                    state_next.count = `WDT_CNT_RST; // R2 R17 R18
                    state_next.firstDone = 1'b1; // R12
                end else if (tick) begin
                    if (atLast) begin
                        tripNow = 1'b1; // R14
                    end else begin
                        state_next.count =
                            CNT_W'(state_reg.count + 1'b1); // R1 R20
                    end
                end
                if (tripNow) begin
                    state_next.phase = wdt_pkg::PH_TRIP;
                    state_next.resetReq = 1'b1;
                    state_next.causeSet = 1'b1; // R24
                    state_next.errPend = 1'b0;
                end
            end
            wdt_pkg::PH_TRIP: begin
                // held here until the chip answers with its internal reset
                state_next.phase = wdt_pkg::PH_TRIP;
            end
            default: begin
                state_next.phase = wdt_pkg::PH_OFF;
            end
        endcase
        // every internal reset, ours included, restarts from a clean count
        if (internalRst) begin
            state_next.phase = wdt_pkg::PH_OFF; // R25
            state_next.count = `WDT_CNT_RST; // R25
            state_next.optLoaded = 1'b0;
            state_next.firstDone = 1'b0;
            state_next.errPend = 1'b0;
            state_next.resetReq = 1'b0;
            state_next.causeSet = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg.phase <= wdt_pkg::PH_OFF;
            state_reg.count <= `WDT_CNT_RST;
            state_reg.opt <= `WDT_OPT_RST;
            state_reg.optLoaded <= 1'b0;
            state_reg.firstDone <= 1'b0;
            state_reg.errPend <= 1'b0;
            state_reg.resetReq <= 1'b0;
            state_reg.causeSet <= 1'b0;
            state_reg.rdata <= `WDT_RESTART_RST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // busRead needs no strobe effect; data is valid at all times
    assign busRdata = state_reg.rdata;
    assign resetReq = state_reg.resetReq;
    assign wdog_reset_cause_flag = state_reg.causeSet;
    assign countValue = state_reg.count;

endmodule

// *** tb/wdt_cpu_model.sv ***
// cpu core model: byte or single-bit writes and fetch/data pulses
// assumes one clock domain; requests move only just after an edge
`timescale 1ns/1ps
module wdt_cpu_model (
    input wire logic clock,
    output logic busWrite,
    output logic busBitOp,
    output logic [15:0] busAddr,
    output logic [7:0] busWdata,
    output logic fetchValid,
    output logic dataAccValid,
    output logic [15:0] accAddr
);
    initial begin
        {busWrite, busBitOp, fetchValid, dataAccValid} = 4'h0;
        busAddr = 16'h0000;
        busWdata = 8'h00;
        accAddr = 16'h0000;
    end
    task automatic wr(input logic [7:0] d, input logic bitOp);
        @(posedge clock);
        busWrite <= 1'b1;
        busBitOp <= bitOp;
        busAddr <= 16'hFF99;
        busWdata <= d;
        @(posedge clock);
        busWrite <= 1'b0;
        busBitOp <= 1'b0;
        // released lines show the inverse, not a stale value
        busAddr <= 16'h0066;
        busWdata <= ~d;
    endtask
    task automatic acc(input logic isFetch, input logic [15:0] a);
        @(posedge clock);
        fetchValid <= isFetch;
        dataAccValid <= !isFetch;
        accAddr <= a;
        @(posedge clock);
        fetchValid <= 1'b0;
        dataAccValid <= 1'b0;
        accAddr <= ~a;
    endtask
endmodule

// *** tb/wdt_top_assertions.sv ***
// port-level checker of the windowed watchdog core
// assumes stopMode stays low in this bench
`timescale 1ns/1ps
module wdt_top_assertions #(
    parameter int CNT_W = 17,
    parameter int ADDR_W = 16
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic internalRst,
    input wire logic [7:0] optionByte,
    input wire logic haltMode,
    input wire logic lowspeed_osc_stop_bit,
    input wire logic busWrite,
    input wire logic busBitOp,
    input wire logic [ADDR_W-1:0] busAddr,
    input wire logic [7:0] busWdata,
    input wire logic [7:0] busRdata,
    input wire logic resetReq,
    input wire logic wdog_reset_cause_flag,
    input wire logic [CNT_W-1:0] countValue
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic regWr;
    assign regWr = busWrite && busAddr == 16'hFF99 && optionByte[4];
    // a halted source clock defers illegal writes, so leave those out
    sequence quiet2;
        (!internalRst && !haltMode && !lowspeed_osc_stop_bit) [*2];
    endsequence
    a_flag_with_req: assert property (resetReq == wdog_reset_cause_flag)
        else $error("cause flag differs from request");
    a_req_one_pulse: assert property (resetReq |=> !resetReq)
        else $error("request wider than one cycle");
    a_rdata_per_enable: assert property ((!internalRst) [*3] |->
        busRdata == (optionByte[4] ? 8'h9A : 8'h1A))
        else $error("readback does not follow enable");
    a_rdata_fixed: assert property (
        busRdata == 8'h9A || busRdata == 8'h1A)
        else $error("readback shows a written value");
    a_key_clears: assert property (regWr && !busBitOp &&
        busWdata == 8'hAC |=> countValue == 17'h0 || resetReq)
        else $error("key write did not clear count");
    a_bad_value: assert property (quiet2 ##0
        (regWr && busWdata != 8'hAC) |=> resetReq)
        else $error("bad value gave no request");
    a_bitop_trip: assert property (
        quiet2 ##0 (regWr && busBitOp) |=> resetReq)
        else $error("single-bit write gave no request");
    a_halt_holds: assert property ((haltMode && !optionByte[0]) [*3]
        ##1 (haltMode && !internalRst) |-> $stable(countValue))
        else $error("count moved while halted");
    // the option byte changes only under internal reset, so skip that cycle
    a_count_ceiling: assert property (
        !internalRst |-> countValue < (18'h1 << (optionByte[3:1] + 5'd10)))
        else $error("count passed the overflow point");
endmodule

bind wdt_top wdt_top_assertions #(.CNT_W(CNT_W), .ADDR_W(ADDR_W)) u_chk (
    .clock, .sys_rst, .internalRst, .optionByte, .haltMode,
    .lowspeed_osc_stop_bit, .busWrite,
    .busBitOp, .busAddr, .busWdata, .busRdata, .resetReq,
    .wdog_reset_cause_flag, .countValue);

// *** tb/windowed_watchdog_timer_tb.sv ***
// self-checking bench of the windowed watchdog core
// assumes the low-speed clock is clock divided by four
`timescale 1ns/1ps
module windowed_watchdog_timer_tb;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic internalRst = 1'b0;
    logic lsClkIn = 1'b0;
    logic [1:0] lsDiv = 2'h0;
    logic [7:0] optionByte = 8'h30;
    logic haltMode = 1'b0;
    logic oscStop = 1'b0;
    logic flashSelfProg = 1'b0;
    logic busWrite, busBitOp, fetchValid, dataAccValid;
    logic [15:0] busAddr, accAddr;
    logic [7:0] busWdata, busRdata;
    logic resetReq, wdog_reset_cause_flag;
    logic [16:0] countValue, held;
    int mismatches = 0;
    int nChecks = 0;
    int n;
    wdt_cpu_model i_cpu (.clock, .busWrite, .busBitOp, .busAddr,
        .busWdata, .fetchValid, .dataAccValid, .accAddr);
    wdt_top i_dut (.clock, .sys_rst, .internalRst, .lsClkIn, .optionByte,
        .haltMode, .stopMode(1'b0), .lowspeed_osc_stop_bit(oscStop),
        .flashSelfProg, .busWrite, .busRead(1'b0), .busBitOp, .busAddr,
        .busWdata, .fetchValid, .fetchAddr(accAddr), .dataAccValid,
        .dataAccAddr(accAddr), .codeAreaEnd(16'h7FFF),
        .ramAreaStart(16'hF000), .ramAreaEnd(16'hF7FF), .busRdata,
        .resetReq, .wdog_reset_cause_flag, .countValue);
    initial forever #50 clock = ~clock;
    always @(posedge clock) begin
        lsDiv <= lsDiv + 2'h1;
        lsClkIn <= lsDiv[1];
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic restart(input logic [7:0] opt);
        @(posedge clock);
        internalRst <= 1'b1;
        optionByte <= opt;
        @(posedge clock);
        internalRst <= 1'b0;
        cyc(3);
    endtask
    task automatic wait_req(input int lim, output int k);
        k = 0;
        while (resetReq !== 1'b1 && k < lim) begin
            cyc(1);
            k++;
        end
    endtask
    task automatic t_regs;
        chk(busRdata, 8'h9A);
        restart(8'h22);
        chk(busRdata, 8'h1A);
        i_cpu.wr(8'h55, 1'b0);
        i_cpu.acc(1'b1, 16'h9000);
        wait_req(40, n);
        chk(n, 40);
        chk(countValue, 0);
        restart(8'h30);
        $display("regs done");
    endtask
    // results are looked at 1 ns after the edge that takes the write,
    // since the reset request stands for that one cycle only
    task automatic t_window;
        cyc(300);
        i_cpu.wr(8'hAC, 1'b0);
        #1;
        chk(countValue, 0);
        i_cpu.wr(8'hAC, 1'b0);
        #1;
        chk(resetReq, 1);
        restart(8'h30);
        chk(countValue < 17'h2, 1);
        i_cpu.wr(8'hAC, 1'b0);
        for (n = 0; countValue !== 17'h3FF && n < 5000; n++) cyc(1);
        i_cpu.wr(8'hAC, 1'b0);
        #1;
        chk(countValue, 0);
        wait_req(2000, n);
        chk(n, 2000);
        // half window: count 0x200 is the first open value
        for (n = 0; countValue !== 17'h200 && n < 5000; n++) cyc(1);
        i_cpu.wr(8'hAC, 1'b0);
        #1;
        chk({resetReq, countValue}, 18'h0_0000);
        for (n = 0; countValue !== 17'h1FF && n < 5000; n++) cyc(1);
        i_cpu.wr(8'hAC, 1'b0);
        #1;
        chk(resetReq, 1);
        restart(8'h30);
        $display("window done");
    endtask
    task automatic t_bad;
        for (int i = 0; i < 2; i++) begin
            i_cpu.wr(8'h55 ^ {8{i[0]}}, 1'b0);
            #1;
            chk({resetReq, wdog_reset_cause_flag}, 2'b11);
            restart(8'h30);
        end
        i_cpu.wr(8'hAC, 1'b1);
        #1;
        chk(resetReq, 1);
        restart(8'h30);
        $display("bad writes done");
    endtask
    task automatic t_halt;
        @(posedge clock) haltMode <= 1'b1;
        cyc(4);
        held = countValue;
        cyc(40);
        chk(countValue, held);
        @(posedge clock) haltMode <= 1'b0;
        cyc(12);
        chk(countValue > held && countValue < held + 17'h5, 1);
        @(posedge clock) oscStop <= 1'b1;
        cyc(4);
        held = countValue;
        cyc(40);
        chk(countValue, held);
        @(posedge clock) oscStop <= 1'b0;
        @(posedge clock) haltMode <= 1'b1;
        i_cpu.wr(8'h55, 1'b0);
        wait_req(20, n);
        chk(n, 20);
        @(posedge clock) haltMode <= 1'b0;
        wait_req(10, n);
        chk(resetReq, 1);
        // lock option set: neither standby nor the stop bit may halt it
        restart(8'h31);
        @(posedge clock) {haltMode, oscStop} <= 2'b11;
        cyc(4);
        held = countValue;
        cyc(40);
        chk(countValue > held, 1);
        @(posedge clock) {haltMode, oscStop} <= 2'b00;
        restart(8'h30);
        $display("halt done");
    endtask
    task automatic t_overflow;
        restart(8'h32);
        @(posedge clock) flashSelfProg <= 1'b1;
        wait_req(9000, n);
        // two low-speed periods of slack either side
        chk(n >= 8184 && n <= 8200, 1);
        restart(8'h30);
        $display("overflow done");
    endtask
    task automatic t_access;
        i_cpu.acc(1'b1, 16'h8000);
        #1;
        chk(resetReq, 1);
        restart(8'h30);
        i_cpu.acc(1'b1, 16'h7FFF);
        i_cpu.acc(1'b0, 16'hF000);
        i_cpu.acc(1'b0, 16'hFB00);
        i_cpu.acc(1'b0, 16'hFFFF);
        wait_req(4, n);
        chk(n, 4);
        i_cpu.acc(1'b0, 16'hFAFF);
        #1;
        chk(resetReq, 1);
        $display("access done");
    endtask
    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        cyc(3);
        t_regs;
        t_window;
        t_bad;
        t_halt;
        t_overflow;
        t_access;
        give_verdict;
    end
    initial begin
        #(100 * 40000);
        mismatches++;
        give_verdict;
    end
endmodule
